// >>> logic/jtp_pkg.sv
// Shared constants, types and state codes of the boundary-scan test access port
package jtp_pkg;

	// Register widths
	localparam int IR_W = 3;
	localparam int ID_W = 32;
	localparam int BSR_W = 109;
	localparam int OUT_CTL_BIT = 108;

	// Instruction codes; three-bit space, unlisted codes fall back to bypass
	localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
	localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
	localparam logic [IR_W-1:0] INS_SAMPLE_Z = 3'h2;
	localparam logic [IR_W-1:0] INS_SAMPLE = 3'h4;
	localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;

	// Values captured into the scan registers
	localparam logic [IR_W-1:0] IR_CAPT = 3'h1;
	localparam logic BYP_CAPT = 1'h0;
	// Identification word; the value is arbitrary, bit 0 must stay one
	localparam logic [ID_W-1:0] ID_VALUE = 32'h0A5C_3001;

	// Values after reset
	localparam logic [IR_W-1:0] IR_RST = INS_IDCODE;
	localparam logic [BSR_W-1:0] BSR_HOLD_RST = {1'h1, {(BSR_W-1){1'h0}}};
	localparam logic [BSR_W-1:0] BSR_SH_RST = {BSR_W{1'h0}};
	localparam logic [ID_W-1:0] ID_SH_RST = 32'h0000_0000;

	// Controller states, one-hot
	typedef enum logic [15:0] {
		ST_RESET = 16'h0001,
		ST_IDLE = 16'h0002,
		ST_SEL_DR = 16'h0004,
		ST_CAP_DR = 16'h0008,
		ST_SH_DR = 16'h0010,
		ST_EX1_DR = 16'h0020,
		ST_PA_DR = 16'h0040,
		ST_EX2_DR = 16'h0080,
		ST_UPD_DR = 16'h0100,
		ST_SEL_IR = 16'h0200,
		ST_CAP_IR = 16'h0400,
		ST_SH_IR = 16'h0800,
		ST_EX1_IR = 16'h1000,
		ST_PA_IR = 16'h2000,
		ST_EX2_IR = 16'h4000,
		ST_UPD_IR = 16'h8000
	} jtp_state_t;

	// Data register chosen by the current instruction
	typedef enum logic [1:0] {
		SEL_BYP = 2'h0,
		SEL_ID = 2'h1,
		SEL_BSR = 2'h2
	} jtp_dsel_t;

	// Test pins as seen by the synchroniser
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} jtp_pins_t;

	// Idle levels of the pins: clock low, pulled-up inputs high
	localparam jtp_pins_t PINS_RST = '{tck: 1'h0, tms: 1'h1, tdi: 1'h1};

endpackage

// >>> logic/jtp_tap.sv
// Boundary-scan test access port: controller, instruction and data scan registers
//
// Function
// R1 - Serial test port with standard controller, instructions and data registers.
// R2 - Unused port: board holds the test clock low, so nothing is clocked.
// R3 - Mode-select and serial-in inputs are pulled up, reading high when open.
// R4 - Unused port: serial output left open, nothing drives it externally.
// R5 - Power-up puts test logic in reset without disturbing memory operation.
// R6 - All test inputs are sampled on the rising test-clock edge.
// R7 - Outputs, serial output included, change only on the falling test-clock edge. TAP_IN_RESET follows the controller state after the rising edge.
// R8 - Controller advances only by mode-select sampled at each rising edge.
// R9 - Current instruction chooses the data register between serial in and out.
// R10 - Serial bits enter at the MSB and move toward the LSB.
// R11 - Serial output presents the LSB, bits leave least significant first.
// R12 - Serial output driven only in shift states, otherwise high impedance.
// R13 - Five rising edges with mode-select high reset the test logic.
// R14 - Three-bit instruction register loads the identification code on reset.
// R15 - Instruction capture loads binary 01 into the two low bits.
// R16 - Bypass is one bit between serial in and out, capturing low.
// R17 - Standard sixteen-state controller with capture, shift, update on both paths.
module jtp_tap (
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire logic TCK,
	input wire logic TMS,
	input wire logic TDI,
	input wire logic [jtp_pkg::BSR_W-1:0] PIN_SAMPLE,
	output logic TDO,
	output logic TDO_OE,
	output logic TMS_PULLUP,
	output logic TDI_PULLUP,
	output logic [jtp_pkg::BSR_W-1:0] BSR_HOLD,
	output logic EXTEST_ON,
	output logic OUT_HIGHZ,
	output logic TAP_IN_RESET
);

	////////////////////////////////////////////////////////////////////////////////
	// Functions

	// Next controller state from the sampled mode-select
	function automatic jtp_pkg::jtp_state_t jtp_next(input jtp_pkg::jtp_state_t st,
		input logic tms);
		jtp_pkg::jtp_state_t ns;
		ns = jtp_pkg::ST_RESET;
		case (st)
			jtp_pkg::ST_RESET: ns = tms ? jtp_pkg::ST_RESET : jtp_pkg::ST_IDLE;
			jtp_pkg::ST_IDLE: ns = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
			jtp_pkg::ST_SEL_DR: ns = tms ? jtp_pkg::ST_SEL_IR : jtp_pkg::ST_CAP_DR;
			jtp_pkg::ST_CAP_DR: ns = tms ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SH_DR;
			jtp_pkg::ST_SH_DR: ns = tms ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SH_DR;
			jtp_pkg::ST_EX1_DR: ns = tms ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_PA_DR;
			jtp_pkg::ST_PA_DR: ns = tms ? jtp_pkg::ST_EX2_DR : jtp_pkg::ST_PA_DR;
			jtp_pkg::ST_EX2_DR: ns = tms ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_SH_DR;
			jtp_pkg::ST_UPD_DR: ns = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
			jtp_pkg::ST_SEL_IR: ns = tms ? jtp_pkg::ST_RESET : jtp_pkg::ST_CAP_IR;
			jtp_pkg::ST_CAP_IR: ns = tms ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SH_IR;
			jtp_pkg::ST_SH_IR: ns = tms ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SH_IR;
			jtp_pkg::ST_EX1_IR: ns = tms ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_PA_IR;
			jtp_pkg::ST_PA_IR: ns = tms ? jtp_pkg::ST_EX2_IR : jtp_pkg::ST_PA_IR;
			jtp_pkg::ST_EX2_IR: ns = tms ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_SH_IR;
			jtp_pkg::ST_UPD_IR: ns = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
			default: ns = jtp_pkg::ST_RESET;
		endcase
		return ns;
	endfunction

	// Data register chosen by an instruction; unknown codes get the bypass bit
	function automatic jtp_pkg::jtp_dsel_t jtp_dsel(input logic [jtp_pkg::IR_W-1:0] ins);
		jtp_pkg::jtp_dsel_t sel;
		sel = jtp_pkg::SEL_BYP;
		case (ins)
			jtp_pkg::INS_IDCODE: sel = jtp_pkg::SEL_ID;
			jtp_pkg::INS_EXTEST: sel = jtp_pkg::SEL_BSR;
			jtp_pkg::INS_SAMPLE: sel = jtp_pkg::SEL_BSR;
			jtp_pkg::INS_SAMPLE_Z: sel = jtp_pkg::SEL_BSR;
			default: sel = jtp_pkg::SEL_BYP;
		endcase
		return sel;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser and test-clock edges

	jtp_pkg::jtp_pins_t pins_meta_ff;
	jtp_pkg::jtp_pins_t pins_ff;
	logic tck_prev_ff;
	logic tck_rise;
	logic tck_fall;

	// Two stages; the first stage is read only by the second
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			pins_meta_ff <= jtp_pkg::PINS_RST;
			pins_ff <= jtp_pkg::PINS_RST;
		end else begin
			pins_meta_ff <= '{tck: TCK, tms: TMS, tdi: TDI};
			pins_ff <= pins_meta_ff;
		end
	end

	// Edge history; a clock held low never yields an edge
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			tck_prev_ff <= 1'h0;
		end else begin
			tck_prev_ff <= pins_ff.tck;
		end
	end

	// R6 rising edge sampling
	assign tck_rise = pins_ff.tck & ~tck_prev_ff;
	// R7 falling edge updates
	assign tck_fall = ~pins_ff.tck & tck_prev_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Controller

	jtp_pkg::jtp_state_t state_ff;
	jtp_pkg::jtp_state_t nxt_state;

	// R8 mode-select steers state
	// R13 five highs reach reset
	assign nxt_state = jtp_next(state_ff, pins_ff.tms);

	// R1 standard test port
	// R5 reset state at power-up
	// R17 sixteen-state controller
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			state_ff <= jtp_pkg::ST_RESET;
		end else if (tck_rise) begin
			state_ff <= nxt_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Instruction register

	logic [jtp_pkg::IR_W-1:0] ir_sh_ff;
	logic [jtp_pkg::IR_W-1:0] ir_ff;
	jtp_pkg::jtp_dsel_t dsel;

	// R9 instruction picks register
	assign dsel = jtp_dsel(ir_ff);

	// Instruction shift stage, moved on rising edges
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			ir_sh_ff <= jtp_pkg::IR_RST;
		end else if (tck_rise) begin
			case (state_ff)
				// R15 capture binary 01
				jtp_pkg::ST_CAP_IR: ir_sh_ff <= jtp_pkg::IR_CAPT;
				// R10 enter at MSB
				jtp_pkg::ST_SH_IR: ir_sh_ff <= {pins_ff.tdi, ir_sh_ff[jtp_pkg::IR_W-1:1]};
				default: ir_sh_ff <= ir_sh_ff;
			endcase
		end
	end

	// Current instruction; changed on the falling edge so decode never glitches mid-shift
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			ir_ff <= jtp_pkg::IR_RST;
		end else if (tck_fall) begin
			// R14 identification on reset
			if (state_ff == jtp_pkg::ST_RESET) begin
				ir_ff <= jtp_pkg::IR_RST;
			end else if (state_ff == jtp_pkg::ST_UPD_IR) begin
				ir_ff <= ir_sh_ff;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Data registers

	logic byp_ff;
	logic [jtp_pkg::ID_W-1:0] id_sh_ff;
	logic [jtp_pkg::BSR_W-1:0] bsr_sh_ff;
	logic dr_cap;
	logic dr_sh;

	assign dr_cap = tck_rise & (state_ff == jtp_pkg::ST_CAP_DR);
	assign dr_sh = tck_rise & (state_ff == jtp_pkg::ST_SH_DR);

	// R16 bypass captures low
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			byp_ff <= jtp_pkg::BYP_CAPT;
		end else if (dsel == jtp_pkg::SEL_BYP) begin
			if (dr_cap) begin
				byp_ff <= jtp_pkg::BYP_CAPT;
			end else if (dr_sh) begin
				byp_ff <= pins_ff.tdi;
			end
		end
	end

	// Identification word, shifted MSB-in
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			id_sh_ff <= jtp_pkg::ID_SH_RST;
		end else if (dsel == jtp_pkg::SEL_ID) begin
			if (dr_cap) begin
				id_sh_ff <= jtp_pkg::ID_VALUE;
			end else if (dr_sh) begin
				// R10 enter at MSB
				id_sh_ff <= {pins_ff.tdi, id_sh_ff[jtp_pkg::ID_W-1:1]};
			end
		end
	end

	// Boundary cells; PIN_SAMPLE must be on this clock, capture takes it as is
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			bsr_sh_ff <= jtp_pkg::BSR_SH_RST;
		end else if (dsel == jtp_pkg::SEL_BSR) begin
			if (dr_cap) begin
				bsr_sh_ff <= PIN_SAMPLE;
			end else if (dr_sh) begin
				// R10 enter at MSB
				bsr_sh_ff <= {pins_ff.tdi, bsr_sh_ff[jtp_pkg::BSR_W-1:1]};
			end
		end
	end

	// Preload latch; the top bit comes back high on reset so the output bus drives
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			BSR_HOLD <= jtp_pkg::BSR_HOLD_RST;
		end else if (tck_fall) begin
			if (state_ff == jtp_pkg::ST_RESET) begin
				BSR_HOLD <= jtp_pkg::BSR_HOLD_RST;
			end else if (state_ff == jtp_pkg::ST_UPD_DR && dsel == jtp_pkg::SEL_BSR) begin
				BSR_HOLD <= bsr_sh_ff;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Serial output

	logic shifting;
	logic nxt_tdo;

	assign shifting = (state_ff == jtp_pkg::ST_SH_IR) || (state_ff == jtp_pkg::ST_SH_DR);

	// R11 least significant bit out
	always_comb begin
		nxt_tdo = byp_ff;
		if (state_ff == jtp_pkg::ST_SH_IR) begin
			nxt_tdo = ir_sh_ff[0];
		end else begin
			case (dsel)
				jtp_pkg::SEL_ID: nxt_tdo = id_sh_ff[0];
				jtp_pkg::SEL_BSR: nxt_tdo = bsr_sh_ff[0];
				default: nxt_tdo = byp_ff;
			endcase
		end
	end

	// R7 output on falling edge
	// R12 drive only while shifting
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			TDO <= 1'h0;
			TDO_OE <= 1'h0;
		end else if (tck_fall) begin
			TDO <= shifting ? nxt_tdo : 1'h0;
			TDO_OE <= shifting;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pad and status outputs

	// R3 pull-ups always on
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			TMS_PULLUP <= 1'h1;
			TDI_PULLUP <= 1'h1;
		end else begin
			TMS_PULLUP <= 1'h1;
			TDI_PULLUP <= 1'h1;
		end
	end

	// R5 reset leaves memory alone
	// Output bus control follows the instruction; one system clock behind it
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			EXTEST_ON <= 1'h0;
			OUT_HIGHZ <= 1'h0;
			TAP_IN_RESET <= 1'h1;
		end else begin
			EXTEST_ON <= (ir_ff == jtp_pkg::INS_EXTEST);
			OUT_HIGHZ <= (ir_ff == jtp_pkg::INS_SAMPLE_Z) ||
				((ir_ff == jtp_pkg::INS_EXTEST) && !BSR_HOLD[jtp_pkg::OUT_CTL_BIT]);
			TAP_IN_RESET <= (state_ff == jtp_pkg::ST_RESET);
		end
	end

endmodule

// >>> verif/jtp_tap_checker.sv
// Port-level assertions for the boundary-scan test access port
module jtp_tap_checker (
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire logic TCK,
	input wire logic TMS,
	input wire logic TDO,
	input wire logic TDO_OE,
	input wire logic TMS_PULLUP,
	input wire logic TDI_PULLUP,
	input wire logic [jtp_pkg::BSR_W-1:0] BSR_HOLD,
	input wire logic EXTEST_ON,
	input wire logic OUT_HIGHZ,
	input wire logic TAP_IN_RESET
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);
	logic tck_ff;
	logic [2:0] ones_ff;
	logic [4:0] rcnt_ff;
	////////////////////////////////////////////////////////////////
	// Count test-clock rises with mode select high; saturates so a long run stays put
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			tck_ff <= 1'h0;
			ones_ff <= 3'h0;
		end else begin
			tck_ff <= TCK;
			if (TCK && !tck_ff)
				ones_ff <= !TMS ? 3'h0 : (ones_ff == 3'h7 ? ones_ff : ones_ff + 3'h1);
		end
	end
	// Cycles spent in reset state
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B)
			rcnt_ff <= 5'h0;
		else
			rcnt_ff <= !TAP_IN_RESET ? 5'h0 : (rcnt_ff == 5'h1F ? rcnt_ff : rcnt_ff + 5'h1);
	end
	////////////////////////////////////////////////////////////////
	a_tdo_fall_only: assert property ($changed(TDO) |-> !TCK && !$past(TCK) && !$past(TCK, 2))
		else $error("serial out moved outside the test-clock low phase");
	a_oe_fall_only: assert property ($changed(TDO_OE) |-> !TCK && !$past(TCK) && !$past(TCK, 2))
		else $error("output enable moved outside the test-clock low phase");
	a_pullups_on: assert property (TMS_PULLUP && TDI_PULLUP)
		else $error("input pull-up switched off");
	a_tdo_quiet: assert property (!TDO_OE |-> !TDO)
		else $error("serial out not low while undriven");
	a_reset_no_drive: assert property (TAP_IN_RESET |-> !TDO_OE)
		else $error("serial out driven in reset state");
	a_five_ones: assert property ((ones_ff == 3'h5 && $changed(ones_ff)) |-> ##[1:8] TAP_IN_RESET)
		else $error("five mode-select ones did not reset");
	a_extest_highz: assert property ((EXTEST_ON && !BSR_HOLD[108]) [*3] |-> OUT_HIGHZ)
		else $error("output bus not high impedance under external test");
	a_hold_preset: assert property (rcnt_ff == 5'h08 |-> BSR_HOLD[108] && !EXTEST_ON)
		else $error("reset state did not preset the hold latch");
	c_shift: cover property ($rose(TDO_OE));
	c_extest: cover property ($rose(EXTEST_ON));
	c_highz: cover property ($rose(OUT_HIGHZ));
endmodule
bind jtp_tap jtp_tap_checker u_chk (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .TCK(TCK), .TMS(TMS),
	.TDO(TDO), .TDO_OE(TDO_OE), .TMS_PULLUP(TMS_PULLUP), .TDI_PULLUP(TDI_PULLUP),
	.BSR_HOLD(BSR_HOLD), .EXTEST_ON(EXTEST_ON), .OUT_HIGHZ(OUT_HIGHZ),
	.TAP_IN_RESET(TAP_IN_RESET));

// >>> verif/jtp_ctl_model.sv
// Test controller model driving the access port pins
module jtp_ctl_model (
	output logic TCK,
	output logic TMS,
	output logic TDI,
	input wire logic TDO,
	input wire logic TDO_OE
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		TCK = 1'h0;
		TMS = 1'h1;
		TDI = 1'h1;
	end
	////////////////////////////////////////////////////////////////
	// serial out only read; the model never drives that pin
	// one 125 ns bit, serial out read before the rise, settled since the last fall moved it
	task automatic tbit(input logic ms, input logic di, output logic do_s, output logic oe_s);
		TMS = ms;
		TDI = di;
		#62.5;
		do_s = TDO;
		oe_s = TDO_OE;
		TCK = 1'h1;
		#62.5;
		TCK = 1'h0;
	endtask
endmodule

// >>> verif/jtp_tap_test.sv
// Self-checking bench of the boundary-scan test access port
module jtp_tap_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 1'h0;
	logic rst_b = 1'h0;
	logic [jtp_pkg::BSR_W-1:0] pin_sample = '0;
	logic [jtp_pkg::BSR_W-1:0] bsr_hold, hold;
	logic tck, tms, tdi, tdo, tdo_oe, tms_pu, tdi_pu, extest_on, out_highz, tap_in_reset;
	logic [127:0] din, got, m;
	logic [2:0] ins [9] = '{jtp_pkg::INS_EXTEST, jtp_pkg::INS_SAMPLE_Z, jtp_pkg::INS_SAMPLE,
		jtp_pkg::INS_IDCODE, 3'h3, 3'h5, 3'h6, jtp_pkg::INS_EXTEST, jtp_pkg::INS_BYPASS};
	int fail_count = 0;
	int n_checks = 0;
	int seed = 32'h1B2BDAD7;
	int w;
	always #5 clk_sys = ~clk_sys;
	jtp_tap uut (.CLK_SYS(clk_sys), .RST_B(rst_b), .TCK(tck), .TMS(tms), .TDI(tdi),
		.PIN_SAMPLE(pin_sample), .TDO(tdo), .TDO_OE(tdo_oe), .TMS_PULLUP(tms_pu),
		.TDI_PULLUP(tdi_pu), .BSR_HOLD(bsr_hold), .EXTEST_ON(extest_on),
		.OUT_HIGHZ(out_highz), .TAP_IN_RESET(tap_in_reset));
	jtp_ctl_model u_ctl (.TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe));
	////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic step(input logic ms);
		logic d, o;
		u_ctl.tbit(ms, 1'h1, d, o);
	endtask
	// Scan n bits from idle and come back to idle
	task automatic scan(input logic ir, input int n, input logic [127:0] di, output logic [127:0] dq);
		logic d, o;
		dq = '0;
		step(1'h1);
		if (ir)
			step(1'h1);
		step(1'h0);
		step(1'h0);
		for (int i = 0; i < n; i++) begin
			u_ctl.tbit(i == n - 1, di[i], d, o);
			dq[i] = d;
			check("tdo_oe shift", 128'(o), 128'h1);
		end
		step(1'h1);
		step(1'h0);
		check("tdo_oe idle", 128'(tdo_oe), 128'h0);
	endtask
	// Length of the selected data register
	function automatic int wid(input logic [2:0] c);
		if (c == jtp_pkg::INS_IDCODE)
			return jtp_pkg::ID_W;
		if (c == jtp_pkg::INS_EXTEST || c == jtp_pkg::INS_SAMPLE_Z || c == jtp_pkg::INS_SAMPLE)
			return jtp_pkg::BSR_W;
		return 1;
	endfunction
	// Value captured into the selected data register
	function automatic logic [127:0] cap(input logic [2:0] c);
		if (wid(c) == 1)
			return 128'(jtp_pkg::BYP_CAPT);
		if (c == jtp_pkg::INS_IDCODE)
			return 128'(jtp_pkg::ID_VALUE);
		return 128'(pin_sample);
	endfunction
	////////////////////////////////////////////////////////////////
	// Hang guard
	initial begin
		#500000;
		fail_count++;
		print_verdict();
	end
	initial begin
		repeat (5) @(negedge clk_sys);
		rst_b = 1'h1;
		repeat (3) @(negedge clk_sys);
		hold = jtp_pkg::BSR_HOLD_RST;
		check("reset flag", 128'(tap_in_reset), 128'h1);
		check("hold preset", 128'(bsr_hold), 128'(hold));
		check("extest idle", 128'(extest_on), 128'h0);
		check("pullups", 128'({tms_pu, tdi_pu}), 128'h3);
		// Scans start from idle, so leave the reset state first
		step(1'h0);
		// every instruction code, data register scanned through
		for (int k = 0; k < 9; k++) begin
			@(negedge clk_sys);
			din = {$random(seed), $random(seed), $random(seed), $random(seed)};
			pin_sample = din[108:0];
			#2.3;
			scan(1'h1, 3, 128'(ins[k]), got);
			check("ir capture", 128'(got[1:0]), 128'h1);
			w = wid(ins[k]);
			din = {$random(seed), $random(seed), $random(seed), $random(seed)};
			// Last external test leaves the bus off, so the later reset must preset it
			din[116] = (k != 0) && (k != 7);
			scan(1'h0, w + 8, din, got);
			m = (128'h1 << (w + 8)) - 128'h1;
			check("dr scan", got & m, (cap(ins[k]) | (din << w)) & m);
			if (wid(ins[k]) == jtp_pkg::BSR_W)
				hold = din[116:8];
			check("bsr_hold", 128'(bsr_hold), 128'(hold));
			check("extest_on", 128'(extest_on), 128'(ins[k] == jtp_pkg::INS_EXTEST));
			check("out_highz", 128'(out_highz), 128'(ins[k] == jtp_pkg::INS_SAMPLE_Z
				|| (ins[k] == jtp_pkg::INS_EXTEST && !hold[108])));
		end
		// four ones from shift stay out of reset, the fifth enters it
		step(1'h1);
		step(1'h0);
		step(1'h0);
		step(1'h0);
		repeat (4) step(1'h1);
		check("four ones", 128'(tap_in_reset), 128'h0);
		step(1'h1);
		check("five ones", 128'(tap_in_reset), 128'h1);
		step(1'h0);
		check("hold after reset", 128'(bsr_hold), 128'(jtp_pkg::BSR_HOLD_RST));
		scan(1'h0, jtp_pkg::ID_W, 128'h0, got);
		check("id after reset", got, 128'(jtp_pkg::ID_VALUE));
		print_verdict();
	end
endmodule
